// >>> design/arfwd_pkg.sv
// Constants shared by the result formatting and window detection block
// Contract
// (RULE1) Right-justified: result sits in high byte bits 1:0 then low byte.
// (RULE2) Right-justified high bits 7:2 copy bit 9 if differential, else zero.
// (RULE3) Left-justified: result fills high byte and low bits 7:6; low 5:0 zero.
// (RULE4) Right-justified low byte holds result bits 7 to 0.
// (RULE5) Left-justified low bits 7:6 hold result LSBs; bits 5:0 constant zero.
// (RULE6) Differential codes are signed two's complement; single-ended unsigned.
// (RULE7) Every completed conversion is compared against the limits automatically.
// (RULE8) Out-of-bound result sets the window match flag and signals the system.
// (RULE9) Software can read the window match flag for polling.
// (RULE10) Limit ordering selects flagging inside or outside the window.
// (RULE11) Software loads each limit as separate high and low bytes.
// (RULE12) Less-than high byte supplies upper eight bits of less-than word.
// (RULE13) Greater-than low byte supplies low eight bits, resets to all ones.
// (RULE14) Compare 16-bit justified words, signed if differential; inside or outside.
// (RULE15) Result bytes and flag update in the same cycle conversion completes.
package arfwd_pkg;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'hBE;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBF;
  localparam logic [7:0] ADDR_UPPER_LOW   = 8'hC4;
  localparam logic [7:0] ADDR_UPPER_HIGH  = 8'hC5;
  localparam logic [7:0] ADDR_LOWER_LOW   = 8'hC6;
  localparam logic [7:0] ADDR_LOWER_HIGH  = 8'hC7;
  localparam logic [7:0] ADDR_CONTROL     = 8'hE8;
  localparam int         CTL_WIN_BIT      = 1;
  localparam int         CTL_LJST_BIT     = 0;
  localparam logic [7:0] RST_RESULT       = 8'h00;
  localparam logic [7:0] RST_UPPER        = 8'hFF;
  localparam logic [7:0] RST_LOWER        = 8'h00;
  localparam logic [7:0] RST_CONTROL      = 8'h00;
endpackage : arfwd_pkg

// >>> design/arfwd_top.sv
// Result formatting, limit registers and window detector
`timescale 1ns/1ps
module arfwd_top (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       conv_done,
  input  wire logic [9:0] conv_data,
  input  wire logic       differential,
  output logic      [7:0] result_low_byte,
  output logic      [7:0] result_high_byte,
  output logic            window_match_flag,
  output logic            left_justify_select,
  output logic            window_event
);
  import arfwd_pkg::*;

  logic [7:0]  upper_limit_low_reg;
  logic [7:0]  upper_limit_high_reg;
  logic [7:0]  lower_limit_low_reg;
  logic [7:0]  lower_limit_high_reg;
  logic [15:0] word_next;
  logic [15:0] gt_word;
  logic [15:0] lt_word;
  logic        above_gt;
  logic        below_lt;
  logic        lt_over_gt;
  logic        match_next;

  // ----------------------------------------------------------------
  // Formatting of the raw result
  // ----------------------------------------------------------------
  always_comb begin
    if (left_justify_select) begin
      word_next = {conv_data, 6'h00}; // RULE3 RULE5
    end else if (differential) begin
      word_next = {{6{conv_data[9]}}, conv_data}; // RULE1 RULE2 RULE4 RULE6
    end else begin
      word_next = {6'h00, conv_data}; // RULE1 RULE2 RULE4
    end
  end

  // ----------------------------------------------------------------
  // Window compare
  // ----------------------------------------------------------------
  assign gt_word = {upper_limit_high_reg, upper_limit_low_reg}; // RULE13
  assign lt_word = {lower_limit_high_reg, lower_limit_low_reg}; // RULE12

  always_comb begin
    if (differential) begin
      above_gt   = $signed(word_next) > $signed(gt_word); // RULE14
      below_lt   = $signed(word_next) < $signed(lt_word);
      lt_over_gt = $signed(lt_word) > $signed(gt_word);
    end else begin
      above_gt   = word_next > gt_word; // RULE14
      below_lt   = word_next < lt_word;
      lt_over_gt = lt_word > gt_word;
    end
    match_next = lt_over_gt ? (above_gt && below_lt) : (above_gt || below_lt); // RULE10
  end

  // ----------------------------------------------------------------
  // Result bytes, loaded on completion or written by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_low_byte  <= RST_RESULT;
      result_high_byte <= RST_RESULT;
    end else if (conv_done) begin
      result_low_byte  <= word_next[7:0]; // RULE15
      result_high_byte <= word_next[15:8];
    end else if (sfr_wr && sfr_addr == ADDR_RESULT_LOW) begin
      result_low_byte  <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == ADDR_RESULT_HIGH) begin
      result_high_byte <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Limit bytes, each loaded separately
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upper_limit_low_reg  <= RST_UPPER; // RULE13
      upper_limit_high_reg <= RST_UPPER;
      lower_limit_low_reg  <= RST_LOWER;
      lower_limit_high_reg <= RST_LOWER;
    end else if (sfr_wr) begin
      if (sfr_addr == ADDR_UPPER_LOW)  upper_limit_low_reg  <= sfr_wdata; // RULE11
      if (sfr_addr == ADDR_UPPER_HIGH) upper_limit_high_reg <= sfr_wdata;
      if (sfr_addr == ADDR_LOWER_LOW)  lower_limit_low_reg  <= sfr_wdata;
      if (sfr_addr == ADDR_LOWER_HIGH) lower_limit_high_reg <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Control bits: flag set wins over a software clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left_justify_select <= RST_CONTROL[CTL_LJST_BIT];
      window_match_flag   <= RST_CONTROL[CTL_WIN_BIT];
    end else begin
      if (sfr_wr && sfr_addr == ADDR_CONTROL) begin
        left_justify_select <= sfr_wdata[CTL_LJST_BIT];
      end
      if (conv_done && match_next) begin
        window_match_flag <= 1'b1; // RULE7 RULE8
      end else if (sfr_wr && sfr_addr == ADDR_CONTROL) begin
        window_match_flag <= sfr_wdata[CTL_WIN_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      window_event <= 1'b0;
    end else begin
      window_event <= conv_done && match_next; // RULE8
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_RESULT_LOW:  sfr_rdata <= result_low_byte;
        ADDR_RESULT_HIGH: sfr_rdata <= result_high_byte;
        ADDR_UPPER_LOW:   sfr_rdata <= upper_limit_low_reg;
        ADDR_UPPER_HIGH:  sfr_rdata <= upper_limit_high_reg;
        ADDR_LOWER_LOW:   sfr_rdata <= lower_limit_low_reg;
        ADDR_LOWER_HIGH:  sfr_rdata <= lower_limit_high_reg;
        ADDR_CONTROL:     sfr_rdata <= {6'h00, window_match_flag, left_justify_select}; // RULE9
        default:          sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence done_rj_s;
    conv_done && !left_justify_select;
  endsequence

  sequence match_done_s;
    conv_done && match_next;
  endsequence

  sequence ctl_write_s;
    sfr_wr && sfr_addr == ADDR_CONTROL;
  endsequence

  right_low_a: assert property (done_rj_s |=> result_low_byte == $past(conv_data[7:0])) // RULE4
    else $error("right-justified low byte wrong");
  right_high_a: assert property (done_rj_s |=> // RULE1
      result_high_byte[1:0] == $past(conv_data[9:8]))
    else $error("right-justified high bits wrong");
  sign_fill_a: assert property (done_rj_s |=> // RULE2
      result_high_byte[7:2] == ($past(differential) ? {6{$past(conv_data[9])}} : 6'h00))
    else $error("high byte fill wrong");
  left_pack_a: assert property (conv_done && left_justify_select |=> // RULE3
      {result_high_byte, result_low_byte} == {$past(conv_data), 6'h00})
    else $error("left-justified word wrong");
  left_zero_a: assert property (conv_done && left_justify_select |=> // RULE5
      result_low_byte[5:0] == 6'h00)
    else $error("left low bits not zero");
  flag_set_a: assert property (match_done_s |=> // RULE8
      window_match_flag && window_event)
    else $error("window flag not set");
  no_event_a: assert property (!(conv_done && match_next) |=> !window_event) // RULE7
    else $error("spurious window event");
  flag_read_a: assert property (sfr_rd && sfr_addr == ADDR_CONTROL |=> // RULE9
      sfr_rdata[CTL_WIN_BIT] == $past(window_match_flag))
    else $error("flag read wrong");
  inside_a: assert property (conv_done && lt_over_gt && !(above_gt && below_lt) // RULE10
      && !window_match_flag && !(sfr_wr && sfr_addr == ADDR_CONTROL) |=> !window_match_flag)
    else $error("inside window misflagged");
  gt_reset_a: assert property ($rose(rstn) |-> upper_limit_low_reg == 8'hFF) // RULE13
    else $error("upper limit low byte reset wrong");

  // ----------------------------------------------------------------
  // Register writes and precedence
  // ----------------------------------------------------------------
  set_wins_a: assert property (match_done_s ##0 ctl_write_s |=> window_match_flag) // RULE8
    else $error("flag clear beat a window match");
  flag_write_a: assert property (ctl_write_s ##0 !(conv_done && match_next) |=> // RULE9
      window_match_flag == $past(sfr_wdata[CTL_WIN_BIT]))
    else $error("flag write not taken");
  justify_write_a: assert property (ctl_write_s |=> // RULE3
      left_justify_select == $past(sfr_wdata[CTL_LJST_BIT]))
    else $error("justify select write not taken");
  gt_low_load_a: assert property (sfr_wr && sfr_addr == ADDR_UPPER_LOW |=> // RULE13
      upper_limit_low_reg == $past(sfr_wdata))
    else $error("upper limit low byte not loaded");
  gt_high_load_a: assert property (sfr_wr && sfr_addr == ADDR_UPPER_HIGH |=> // RULE11
      upper_limit_high_reg == $past(sfr_wdata))
    else $error("upper limit high byte not loaded");
  lt_low_load_a: assert property (sfr_wr && sfr_addr == ADDR_LOWER_LOW |=> // RULE11
      lower_limit_low_reg == $past(sfr_wdata))
    else $error("lower limit low byte not loaded");
  lt_high_load_a: assert property (sfr_wr && sfr_addr == ADDR_LOWER_HIGH |=> // RULE12
      lower_limit_high_reg == $past(sfr_wdata))
    else $error("lower limit high byte not loaded");
  // A software write never splits a freshly converted result
  conv_wins_a: assert property (conv_done && sfr_wr |=> // RULE15
      {result_high_byte, result_low_byte} == $past(word_next))
    else $error("result bytes not from the conversion");
  result_hold_a: assert property (!conv_done && !(sfr_wr && (sfr_addr == ADDR_RESULT_LOW // RULE15
      || sfr_addr == ADDR_RESULT_HIGH)) |=> $stable({result_high_byte, result_low_byte}))
    else $error("result bytes changed without cause");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) // RULE9
    else $error("read data changed without a read");
endmodule // arfwd_top

// >>> sim/arfwd_top_tb.sv
// Self-checking testbench for the result formatting and window block
`timescale 1ns/1ps
module arfwd_top_tb;
  import arfwd_pkg::*;
  logic        clk, rstn, sfr_wr, sfr_rd, conv_done, differential;
  logic        win_flag, ljst, win_ev, cd_d, rd_d, m_lj, m_flag;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, res_lo, res_hi;
  logic [9:0]  conv_data;
  logic [15:0] gt, lt, lw;
  logic [18:0] e;
  logic [7:0]  rq[$];
  logic [18:0] cq[$];
  int          errors, checks;

  arfwd_top arfwd_top_i (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .conv_done(conv_done),
    .conv_data(conv_data), .differential(differential), .result_low_byte(res_lo),
    .result_high_byte(res_hi), .window_match_flag(win_flag),
    .left_justify_select(ljst), .window_event(win_ev));

  always #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    case (a)
      ADDR_UPPER_LOW:   gt[7:0] = d;
      ADDR_UPPER_HIGH:  gt[15:8] = d;
      ADDR_LOWER_LOW:   lt[7:0] = d;
      ADDR_LOWER_HIGH:  lt[15:8] = d;
      ADDR_CONTROL:     {m_flag, m_lj} = d[1:0];
      ADDR_RESULT_LOW:  lw[7:0] = d;
      ADDR_RESULT_HIGH: lw[15:8] = d;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    rq.push_back(x);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
  endtask

  task automatic conv(input logic [9:0] d, input logic df, input logic cl);
    logic m;
    lw = m_lj ? {d, 6'h00} : (df ? {{6{d[9]}}, d} : {6'h00, d});
    if (df)
      m = ($signed(lt) > $signed(gt)) ? ($signed(lw) > $signed(gt) && $signed(lw) < $signed(lt))
        : ($signed(lw) > $signed(gt) || $signed(lw) < $signed(lt));
    else
      m = (lt > gt) ? (lw > gt && lw < lt) : (lw > gt || lw < lt);
    // A flag clear written with the conversion loses to a match
    m_flag = cl ? m : (m_flag | m);
    cq.push_back({m_lj, lw, m_flag, m});
    @(posedge clk);
    conv_done <= 1'b1;
    conv_data <= d;
    differential <= df;
    sfr_addr <= ADDR_CONTROL;
    sfr_wdata <= {7'h00, m_lj};
    sfr_wr <= cl;
    @(posedge clk);
    conv_done <= 1'b0;
    sfr_wr <= 1'b0;
  endtask

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge clk) begin
    cd_d <= conv_done;
    rd_d <= sfr_rd;
    if (cd_d) begin
      e = cq.pop_front();
      chk("result_word", {res_hi, res_lo}, e[17:2]);
      chk("match_flag", 16'(win_flag), 16'(e[1]));
      chk("window_event", 16'(win_ev), 16'(e[0]));
      chk("justify_select", 16'(ljst), 16'(e[18]));
    end else if (rstn)
      chk("idle_event", 16'(win_ev), 16'h0000);
    if (rd_d)
      chk("sfr_rdata", 16'(sfr_rdata), 16'(rq.pop_front()));
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(25ns * 8000);
    errors++;
    end_of_test();
  end

  initial begin
    {clk, rstn, sfr_wr, sfr_rd, conv_done, differential, sfr_addr, sfr_wdata} = '0;
    {conv_data, m_lj, m_flag, errors, checks, lw, lt} = '0;
    gt = 16'hFFFF;
    void'($urandom(32'hF1A4));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_UPPER_LOW, 8'hFF);
    rd(ADDR_LOWER_HIGH, RST_LOWER);
    rd(ADDR_RESULT_HIGH, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    rd(8'h10, 8'h00);
    conv(10'h3FF, 1'b0, 1'b0);
    $display("reset and first conversion done");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CONTROL, {7'h00, k[0]});
      for (int a = 0; a < 4; a++)
        wr(8'(ADDR_UPPER_LOW + a), 8'($urandom));
      rd(ADDR_LOWER_HIGH, lt[15:8]);
      for (int j = 0; j < 10; j++)
        conv(10'($urandom), k[1], 1'($urandom));
      conv(gt[15:6], k[1], 1'b0);
      rd(ADDR_CONTROL, {6'h00, m_flag, m_lj});
      rd(ADDR_RESULT_LOW, lw[7:0]);
      wr(ADDR_RESULT_HIGH, 8'($urandom));
      rd(ADDR_RESULT_HIGH, lw[15:8]);
      $display("test %0d done", k);
    end
    repeat (2) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    {m_lj, m_flag, lw, lt} = '0;
    gt = {RST_UPPER, RST_UPPER};
    rd(ADDR_UPPER_LOW, 8'hFF);
    rd(ADDR_LOWER_HIGH, RST_LOWER);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_RESULT_LOW, 8'h00);
    conv(10'h200, 1'b1, 1'b0);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule // arfwd_top_tb
